// file: core/dbsmr_top.sv
// dbsmr_top: status and mode word with host strobe port for two buses
// assumes host pins are asynchronous; encoder and decoder share the clock
`timescale 1ns/100ps
module dbsmr_top
  import dbsmr_pkg::*;
#(
  parameter int WIN_OPEN  = WIN_OPEN_CYC,
  parameter int WIN_CLOSE = WIN_CLOSE_CYC,
  parameter int WORD_LEN  = WORD_CYC
) (
  // clock and reset
  input  wire logic              I_CORE_CLK,
  input  wire logic              I_RSTN,
  // host strobe port
  input  wire logic              I_ACCESS_STROBE_N,
  input  wire logic              I_REG_SEL,
  input  wire logic              I_READ_NWRITE,
  input  wire logic              I_BUS_SELECT_PIN,
  input  wire logic [WORD_W-1:0] I_DATA,
  output logic      [WORD_W-1:0] O_DATA,
  output logic                   O_DATA_OE,
  input  wire logic              I_SYNC,
  output logic                   O_SYNC,
  output logic                   O_SYNC_OE,
  // status pins
  output logic                   O_WORD_ARRIVED_A,
  output logic                   O_WORD_ARRIVED_B,
  output logic                   O_DECODE_FAULT,
  // decoder side
  input  wire dbsmr_rx_t         I_RX_A,
  input  wire dbsmr_rx_t         I_RX_B,
  // encoder side
  output dbsmr_tx_t              O_TX,
  input  wire logic              I_TX_START,
  output logic                   O_TRANSMIT_OFF_A,
  output logic                   O_TRANSMIT_OFF_B,
  output logic                   O_RECEIVER_ON_A,
  output logic                   O_RECEIVER_ON_B
);
  // synchronised host pins
  logic              strobe_n_s;
  logic [3:0]        ctl_s;
  logic [WORD_W-1:0] data_s;
  logic              strobe_n_d_ff;

  dbsmr_pin_sync #(
    .W         (1),
    .RESET_VAL (STROBE_IDLE)
  ) u_sync_strobe (
    .i_clk  (I_CORE_CLK),
    .i_rstn (I_RSTN),
    .i_pin  (I_ACCESS_STROBE_N),
    .o_sync (strobe_n_s)
  );

  dbsmr_pin_sync #(
    .W         (4),
    .RESET_VAL (1'b0)
  ) u_sync_ctl (
    .i_clk  (I_CORE_CLK),
    .i_rstn (I_RSTN),
    .i_pin  ({I_REG_SEL, I_READ_NWRITE, I_BUS_SELECT_PIN, I_SYNC}),
    .o_sync (ctl_s)
  );

  dbsmr_pin_sync #(
    .W         (WORD_W),
    .RESET_VAL (1'b0)
  ) u_sync_data (
    .i_clk  (I_CORE_CLK),
    .i_rstn (I_RSTN),
    .i_pin  (I_DATA),
    .o_sync (data_s)
  );

  wire reg_sel_s  = ctl_s[3];
  wire rd_s       = ctl_s[2];
  wire bus_pin_s  = ctl_s[1];
  wire sync_pin_s = ctl_s[0];

  // strobe decode: writes and read clear act on the rising edge that ends the cycle; reads drive while strobe is low
  wire strobe_end = strobe_n_s & ~strobe_n_d_ff;
  wire strobe_on  = ~strobe_n_s;
  wire wr_sam     = strobe_end & reg_sel_s & ~rd_s;
  wire wr_tx      = strobe_end & ~reg_sel_s & ~rd_s;
  wire rd_rx_end  = strobe_end & ~reg_sel_s & rd_s;
  wire rd_sam_on  = strobe_on & reg_sel_s & rd_s;
  wire rd_rx_on   = strobe_on & ~reg_sel_s & rd_s;

  // configuration bits
  logic [CFG_W-1:0] cfg_ff;
  wire  [CFG_W-1:0] nxt_cfg = wr_sam ? data_s[CFG_W-1:0] : cfg_ff;

  wire bus_b_sel = cfg_ff[BIT_BUS_B_SEL] | bus_pin_s;
  wire sync_cmd  = cfg_ff[BIT_TX_SYNC] | sync_pin_s;

  // per-bus receive status
  logic [1:0]        arrived;
  logic [1:0]        sync_kind;
  logic [1:0]        idle;
  logic [1:0]        fault;
  logic [WORD_W-1:0] rx_word [2];
  dbsmr_rx_t         rx_in [2];
  wire  [1:0]        rx_on = {cfg_ff[BIT_RX_ON_B], cfg_ff[BIT_RX_ON_A]};
  wire  [1:0]        rd_clr = {rd_rx_end & bus_b_sel,
                               rd_rx_end & ~bus_b_sel};

  assign rx_in[0] = I_RX_A;
  assign rx_in[1] = I_RX_B;

  for (genvar g = 0; g < 2; g++) begin : g_bus
    dbsmr_bus_status u_status (
      .i_clk       (I_CORE_CLK),
      .i_rstn      (I_RSTN),
      .i_enable    (rx_on[g]),
      .i_read_clr  (rd_clr[g]),
      .i_rx        (rx_in[g]),
      .o_arrived   (arrived[g]),
      .o_sync_kind (sync_kind[g]),
      .o_idle      (idle[g]),
      .o_fault     (fault[g]),
      .o_word      (rx_word[g])
    );
  end

  // transmit window timer
  logic               tx_busy_ff;
  logic [TIMER_W-1:0] tx_cnt_ff;
  wire  tx_last    = tx_cnt_ff == TIMER_W'(WORD_LEN - 1);
  wire  in_window  = tx_cnt_ff >= TIMER_W'(WIN_OPEN) &&
                     tx_cnt_ff <  TIMER_W'(WIN_CLOSE);
  wire  next_word_window = ~tx_busy_ff | in_window;
  wire  nxt_tx_busy = I_TX_START | (tx_busy_ff & ~tx_last);
  wire  [TIMER_W-1:0] nxt_tx_cnt = I_TX_START ? '0 :
                                   tx_busy_ff ? tx_cnt_ff + 1'b1 :
                                   tx_cnt_ff;

  // assembled status and mode word
  wire [WORD_W-1:0] status_mode_word = {
    next_word_window,
    fault[1], idle[1], sync_kind[1], arrived[1],
    fault[0], idle[0], sync_kind[0], arrived[0],
    1'b0,
    cfg_ff
  };

  wire [WORD_W-1:0] rx_sel_word  = bus_b_sel ? rx_word[1] : rx_word[0];
  wire              rx_sel_sync  = bus_b_sel ? sync_kind[1] : sync_kind[0];
  wire [WORD_W-1:0] nxt_data_out = reg_sel_s ? status_mode_word
                                             : rx_sel_word;

  logic [WORD_W-1:0] data_out_ff;
  logic              sync_out_ff;
  dbsmr_tx_t         tx_ff;
  dbsmr_tx_t         nxt_tx;

  assign nxt_tx = '{go:       wr_tx,
                    bus_b:    bus_b_sel,
                    sync_cmd: sync_cmd,
                    word:     wr_tx ? data_s : tx_ff.word};

  always_ff @(posedge I_CORE_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      strobe_n_d_ff <= STROBE_IDLE;
      cfg_ff        <= CFG_RESET;
      data_out_ff   <= '0;
      sync_out_ff   <= 1'b0;
      tx_ff         <= '0;
      tx_busy_ff    <= 1'b0;
      tx_cnt_ff     <= '0;
    end else begin
      strobe_n_d_ff <= strobe_n_s;
      cfg_ff        <= nxt_cfg;
      data_out_ff   <= nxt_data_out;
      sync_out_ff   <= rx_sel_sync;
      tx_ff         <= nxt_tx;
      tx_busy_ff    <= nxt_tx_busy;
      tx_cnt_ff     <= nxt_tx_cnt;
    end
  end

  // outputs
  assign O_DATA           = data_out_ff;
  assign O_DATA_OE        = rd_sam_on | rd_rx_on;
  assign O_SYNC           = sync_out_ff;
  assign O_SYNC_OE        = rd_rx_on;
  assign O_WORD_ARRIVED_A = arrived[0];
  assign O_WORD_ARRIVED_B = arrived[1];
  assign O_DECODE_FAULT   = |fault;
  assign O_TX             = tx_ff;
  assign O_TRANSMIT_OFF_A = cfg_ff[BIT_TX_OFF_A];
  assign O_TRANSMIT_OFF_B = cfg_ff[BIT_TX_OFF_B];
  assign O_RECEIVER_ON_A  = cfg_ff[BIT_RX_ON_A];
  assign O_RECEIVER_ON_B  = cfg_ff[BIT_RX_ON_B];

  // checks
  sequence s_sam_write;
    strobe_n_s && !strobe_n_d_ff && reg_sel_s && !rd_s;
  endsequence

  sequence s_tx_write;
    strobe_n_s && !strobe_n_d_ff && !reg_sel_s && !rd_s;
  endsequence

  property p_cfg_write;
    @(posedge I_CORE_CLK) disable iff (!I_RSTN)
      s_sam_write |=> cfg_ff == $past(data_s[CFG_W-1:0])
                      ##1 O_TRANSMIT_OFF_A == cfg_ff[0];
  endproperty
  a_cfg_write: assert property (p_cfg_write)
    else $error("config bits not taken from write data");

  property p_tx_sync;
    @(posedge I_CORE_CLK) disable iff (!I_RSTN)
      s_tx_write |=> O_TX.go &&
        O_TX.sync_cmd == $past(cfg_ff[BIT_TX_SYNC] | sync_pin_s);
  endproperty
  a_tx_sync: assert property (p_tx_sync)
    else $error("transmit sync kind wrong");

  property p_tx_bus;
    @(posedge I_CORE_CLK) disable iff (!I_RSTN)
      s_tx_write |=> O_TX.bus_b == $past(cfg_ff[BIT_BUS_B_SEL] | bus_pin_s)
                     && O_TX.word == $past(data_s) ##1 !O_TX.go;
  endproperty
  a_tx_bus: assert property (p_tx_bus)
    else $error("transmit bus or word wrong");

  property p_rx_read;
    @(posedge I_CORE_CLK) disable iff (!I_RSTN)
      rd_rx_on |=> O_DATA == $past(bus_b_sel ? rx_word[1] : rx_word[0]);
  endproperty
  a_rx_read: assert property (p_rx_read)
    else $error("read returned word of wrong bus");

  property p_sam_read;
    @(posedge I_CORE_CLK) disable iff (!I_RSTN)
      rd_sam_on |=> !O_DATA[BIT_UNUSED] &&
        O_DATA[CFG_W-1:0] == $past(cfg_ff);
  endproperty
  a_sam_read: assert property (p_sam_read)
    else $error("status word read back wrong");

  property p_sync_out;
    @(posedge I_CORE_CLK) disable iff (!I_RSTN)
      (rd_rx_on && $stable(bus_b_sel)) |->
        O_SYNC == $past(bus_b_sel ? sync_kind[1] : sync_kind[0]);
  endproperty
  a_sync_out: assert property (p_sync_out)
    else $error("sync pin not showing stored sync kind");

  property p_window_closed;
    @(posedge I_CORE_CLK) disable iff (!I_RSTN)
      I_TX_START |=> !status_mode_word[BIT_NEXT_WINDOW];
  endproperty
  a_window_closed: assert property (p_window_closed)
    else $error("next word window open at transmit start");

  property p_window_count;
    @(posedge I_CORE_CLK) disable iff (!I_RSTN)
      tx_busy_ff |-> next_word_window ==
        (tx_cnt_ff >= TIMER_W'(WIN_OPEN) && tx_cnt_ff < TIMER_W'(WIN_CLOSE));
  endproperty
  a_window_count: assert property (p_window_count)
    else $error("next word window outside its span");

  sequence s_rx_read_end;
    strobe_n_s && !strobe_n_d_ff && !reg_sel_s && rd_s;
  endsequence

  property p_status_flags;
    @(posedge I_CORE_CLK) disable iff (!I_RSTN)
      rd_sam_on |=> O_DATA[BIT_BUS_A_BASE] == $past(O_WORD_ARRIVED_A)
                    && O_DATA[BIT_BUS_B_BASE] == $past(O_WORD_ARRIVED_B)
                    && $past(O_DECODE_FAULT) == (O_DATA[BIT_BUS_A_BASE+3]
                                                | O_DATA[BIT_BUS_B_BASE+3]);
  endproperty
  a_status_flags: assert property (p_status_flags)
    else $error("status word flags differ from status pins");

  property p_read_clears;
    @(posedge I_CORE_CLK) disable iff (!I_RSTN)
      (s_rx_read_end ##0 (!bus_b_sel && !I_RX_A.word_ok))
        |=> !O_WORD_ARRIVED_A;
  endproperty
  a_read_clears: assert property (p_read_clears)
    else $error("bus A arrived flag kept after receive word read");

  property p_sync_drive;
    @(posedge I_CORE_CLK) disable iff (!I_RSTN)
      (!strobe_n_s && !reg_sel_s && rd_s) |-> O_SYNC_OE && O_DATA_OE;
  endproperty
  a_sync_drive: assert property (p_sync_drive)
    else $error("sync or data pins not driven during word read");

  property p_write_quiet;
    @(posedge I_CORE_CLK) disable iff (!I_RSTN)
      (!strobe_n_s && !rd_s) |-> !O_DATA_OE && !O_SYNC_OE;
  endproperty
  a_write_quiet: assert property (p_write_quiet)
    else $error("device drove data or sync pins during a write");

  property p_window_end;
    @(posedge I_CORE_CLK) disable iff (!I_RSTN)
      $fell(tx_busy_ff) |-> status_mode_word[BIT_NEXT_WINDOW];
  endproperty
  a_window_end: assert property (p_window_end)
    else $error("next word window low after transmission ended");
endmodule : dbsmr_top

// file: core/dbsmr_pkg.sv
// dbsmr_pkg: constants and carriers for the dual bus status and mode word
// assumes one 250 MHz core clock and the encoder/decoder on the same clock
// Behaviour
// - bits 0 and 1 reset low; a one turns off bus A or B transmitter
// - bits 2 and 3 reset high; clearing one makes that bus ignored
// - transmit write: bit 4 OR sync pin picks command or data sync
// - transmit write: bit 5 OR select pin picks bus A or bus B
// - data read: bit 5 OR select pin returns bus A or bus B word
// - bit 6 is unused, read-only, always zero
// - bit 7 mirrors bus A word-arrived pin, set on valid word, resets low
// - word-arrived clears on receive word read or new word start
// - back to back words keep word-arrived high about 3 us
// - receive word held until word-arrived rises again, host reads first
// - bit 8 holds last bus A sync kind, one for command, resets low
// - reading a receive word drives its stored sync kind on sync pin
// - bit 9 high while bus A is idle, low with traffic, resets low
// - bit 10 rises on a badly encoded bus A word, resets low
// - bits 11 to 14 repeat bits 7 to 10 for bus B
// - bit 15 rises 3.5 us and falls 18.5 us after transmit start
package dbsmr_pkg;
  // field positions of the status and mode word
  localparam int BIT_TX_OFF_A    = 0;
  localparam int BIT_TX_OFF_B    = 1;
  localparam int BIT_RX_ON_A     = 2;
  localparam int BIT_RX_ON_B     = 3;
  localparam int BIT_TX_SYNC     = 4;
  localparam int BIT_BUS_B_SEL   = 5;
  localparam int BIT_UNUSED      = 6;
  localparam int BIT_BUS_A_BASE  = 7;
  localparam int BIT_BUS_B_BASE  = 11;
  localparam int BIT_NEXT_WINDOW = 15;
  localparam int CFG_W           = 6;
  localparam int WORD_W          = 16;

  // value after reset of the writable bits
  localparam logic [CFG_W-1:0] CFG_RESET = 6'h0c;
  // synchroniser reset values
  localparam logic STROBE_IDLE = 1'b1;

  // transmit window timing
  localparam int CLK_MHZ          = 250;
  localparam int WIN_OPEN_NS      = 3500;
  localparam int WIN_CLOSE_NS     = 18500;
  localparam int WORD_TIME_NS     = 20000;
  localparam int WIN_OPEN_CYC     = (WIN_OPEN_NS * CLK_MHZ + 999) / 1000;
  localparam int WIN_CLOSE_CYC    = (WIN_CLOSE_NS * CLK_MHZ) / 1000;
  localparam int WORD_CYC         = (WORD_TIME_NS * CLK_MHZ) / 1000;
  localparam int TIMER_W          = 15;

  // decoder report for one bus
  typedef struct packed {
    logic              word_ok;
    logic              word_bad;
    logic              word_begin;
    logic              line_busy;
    logic              sync_cmd;
    logic [WORD_W-1:0] word;
  } dbsmr_rx_t;

  // transmit request toward the encoder
  typedef struct packed {
    logic              go;
    logic              bus_b;
    logic              sync_cmd;
    logic [WORD_W-1:0] word;
  } dbsmr_tx_t;
endpackage : dbsmr_pkg

// file: core/dbsmr_pin_sync.sv
// dbsmr_pin_sync: two flip-flop synchroniser for a group of pins
// assumes pins are asynchronous to the core clock
`timescale 1ns/100ps
module dbsmr_pin_sync #(
  parameter int         W         = 1,
  parameter logic [0:0] RESET_VAL = 1'b0
) (
  // clock and reset
  input  wire logic         i_clk,
  input  wire logic         i_rstn,
  // pins and synchronised copy
  input  wire logic [W-1:0] i_pin,
  output logic      [W-1:0] o_sync
);
  logic [W-1:0] meta_ff;
  logic [W-1:0] sync_ff;

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      meta_ff <= {W{RESET_VAL}};
      sync_ff <= {W{RESET_VAL}};
    end else begin
      meta_ff <= i_pin;
      sync_ff <= meta_ff;
    end
  end

  assign o_sync = sync_ff;
endmodule : dbsmr_pin_sync

// file: core/dbsmr_bus_status.sv
// dbsmr_bus_status: receive word holder and status flags of one bus
// assumes decoder reports arrive on the core clock as one-cycle pulses
`timescale 1ns/100ps
module dbsmr_bus_status
  import dbsmr_pkg::*;
(
  // clock and reset
  input  wire logic              i_clk,
  input  wire logic              i_rstn,
  // control
  input  wire logic              i_enable,
  input  wire logic              i_read_clr,
  input  wire dbsmr_rx_t         i_rx,
  // status
  output logic                   o_arrived,
  output logic                   o_sync_kind,
  output logic                   o_idle,
  output logic                   o_fault,
  output logic      [WORD_W-1:0] o_word
);
  logic              arrived_ff;
  logic              sync_ff;
  logic              idle_ff;
  logic              fault_ff;
  logic [WORD_W-1:0] word_ff;

  // disabled receiver ignores everything on its bus
  wire good_word  = i_enable & i_rx.word_ok & ~i_rx.word_bad;
  wire bad_word   = i_enable & i_rx.word_bad;
  wire word_begin = i_enable & i_rx.word_begin;
  wire line_busy  = i_enable & i_rx.line_busy;

  // set wins over clear
  wire nxt_arrived = good_word |
                     (arrived_ff & ~i_read_clr & ~word_begin);
  wire nxt_fault   = bad_word | (fault_ff & ~good_word);

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      arrived_ff <= 1'b0;
      sync_ff    <= 1'b0;
      idle_ff    <= 1'b0;
      fault_ff   <= 1'b0;
      word_ff    <= '0;
    end else begin
      arrived_ff <= nxt_arrived;
      idle_ff    <= ~line_busy;
      fault_ff   <= nxt_fault;
      if (good_word) begin
        sync_ff <= i_rx.sync_cmd;
        word_ff <= i_rx.word;
      end
    end
  end

  assign o_arrived   = arrived_ff;
  assign o_sync_kind = sync_ff;
  assign o_idle      = idle_ff;
  assign o_fault     = fault_ff;
  assign o_word      = word_ff;

  sequence s_good_word;
    i_enable && i_rx.word_ok && !i_rx.word_bad;
  endsequence

  property p_word_capture;
    @(posedge i_clk) disable iff (!i_rstn)
      s_good_word |=> o_arrived && o_word == $past(i_rx.word)
                      && o_sync_kind == $past(i_rx.sync_cmd);
  endproperty
  a_word_capture: assert property (p_word_capture)
    else $error("good word not captured with arrived flag");

  property p_fault_no_arrive;
    @(posedge i_clk) disable iff (!i_rstn)
      (i_enable && i_rx.word_bad) |=> o_fault && !$rose(o_arrived);
  endproperty
  a_fault_no_arrive: assert property (p_fault_no_arrive)
    else $error("faulty word raised arrived or missed fault");

  property p_disabled_quiet;
    @(posedge i_clk) disable iff (!i_rstn)
      !i_enable |=> !$rose(o_arrived) && !$rose(o_fault) && o_idle;
  endproperty
  a_disabled_quiet: assert property (p_disabled_quiet)
    else $error("disabled receiver reacted to its bus");

  property p_arrived_clear;
    @(posedge i_clk) disable iff (!i_rstn)
      (o_arrived && (i_read_clr || (i_enable && i_rx.word_begin))
       && !(i_enable && i_rx.word_ok && !i_rx.word_bad)) |=> !o_arrived;
  endproperty
  a_arrived_clear: assert property (p_arrived_clear)
    else $error("arrived flag not cleared by read or word start");

  property p_idle_follows;
    @(posedge i_clk) disable iff (!i_rstn)
      (i_enable && i_rx.line_busy) |=> !o_idle;
  endproperty
  a_idle_follows: assert property (p_idle_follows)
    else $error("idle flag high during bus traffic");
endmodule : dbsmr_bus_status

// file: tb/dbsmr_host_model.sv
// dbsmr_host_model: host processor running strobe read and write cycles
// assumes the bench resolves data and sync wires from both enables
`timescale 1ns/100ps
module dbsmr_host_model
  import dbsmr_pkg::*;
(
  // clock
  input  wire logic              i_clk,
  // host pins
  output logic                   o_strobe_n,
  output logic                   o_reg_sel,
  output logic                   o_read_nwrite,
  output logic                   o_bus_select,
  output logic      [WORD_W-1:0] o_data,
  output logic                   o_data_oe,
  output logic                   o_sync,
  output logic                   o_sync_oe,
  // resolved wires and read result
  input  wire logic [WORD_W-1:0] i_data,
  input  wire logic              i_sync,
  output logic      [WORD_W:0]   o_result,
  output logic                   o_done
);
  initial begin
    o_strobe_n    = 1'b1;
    o_reg_sel     = 1'b0;
    o_read_nwrite = 1'b1;
    o_bus_select  = 1'b0;
    o_data        = 16'h0000;
    o_data_oe     = 1'b0;
    o_sync        = 1'b0;
    o_sync_oe     = 1'b0;
    o_result      = 17'h00000;
    o_done        = 1'b0;
  end

  // one strobe cycle; pins held four edges past the strobe rise
  task automatic access(input logic rnw, input logic rsel, input logic sel,
                        input logic sy, input logic [WORD_W-1:0] wd);
    @(posedge i_clk);
    o_strobe_n    <= 1'b0;
    o_reg_sel     <= rsel;
    o_read_nwrite <= rnw;
    o_bus_select  <= sel;
    o_data        <= wd;
    o_sync        <= sy;
    o_data_oe     <= !rnw;
    o_sync_oe     <= !rnw;
    repeat (6) @(posedge i_clk);
    o_result      <= {i_sync, i_data};
    o_strobe_n    <= 1'b1;
    repeat (4) @(posedge i_clk);
    o_data_oe     <= 1'b0;
    o_sync_oe     <= 1'b0;
    o_data        <= ~wd;
    o_sync        <= ~sy;
    o_done        <= rnw;
    @(posedge i_clk);
    o_done        <= 1'b0;
  endtask : access
endmodule : dbsmr_host_model

// file: tb/test_dual_bus_status_mode_register.sv
// test_dual_bus_status_mode_register: self-checking bench of dbsmr_top
// assumes shortened transmit window parameters 40, 120 and 160 cycles
`timescale 1ns/100ps
module test_dual_bus_status_mode_register;
  import dbsmr_pkg::*;
  logic              clk = 1'b0;
  logic              rst_n = 1'b0;
  logic              strobe_n, reg_sel, rnw, sel_pin, h_data_oe;
  logic              h_sync, h_sync_oe, h_done, o_data_oe, o_sync;
  logic              o_sync_oe, arr_a, arr_b, fault, tx_start = 1'b0;
  logic              off_a, off_b, on_a, on_b;
  logic [WORD_W-1:0] h_data, o_data, data_w;
  logic [WORD_W:0]   h_result;
  logic              sync_w;
  dbsmr_rx_t         rx_a = '0;
  dbsmr_rx_t         rx_b = '0;
  dbsmr_tx_t         tx;
  logic [16:0]       exp_rd[$];
  logic [17:0]       exp_tx[$];
  logic [5:0]        cfg = 6'h0c;
  logic [7:0]        st = 8'h44;
  int                n_errors = 0;
  int                checks = 0;
  int                cycles = 0;
  int                seed = 95;

  always #2 clk = ~clk;
  // pull-downs on the shared data and sync wires
  assign data_w = o_data_oe ? o_data : (h_data_oe ? h_data : 16'h0000);
  assign sync_w = o_sync_oe ? o_sync : (h_sync_oe ? h_sync : 1'b0);

  dbsmr_top #(.WIN_OPEN(40), .WIN_CLOSE(120), .WORD_LEN(160)) i_dbsmr_top (
    .I_CORE_CLK(clk), .I_RSTN(rst_n), .I_ACCESS_STROBE_N(strobe_n),
    .I_REG_SEL(reg_sel), .I_READ_NWRITE(rnw), .I_BUS_SELECT_PIN(sel_pin),
    .I_DATA(data_w), .O_DATA(o_data), .O_DATA_OE(o_data_oe),
    .I_SYNC(sync_w), .O_SYNC(o_sync), .O_SYNC_OE(o_sync_oe),
    .O_WORD_ARRIVED_A(arr_a), .O_WORD_ARRIVED_B(arr_b),
    .O_DECODE_FAULT(fault), .I_RX_A(rx_a), .I_RX_B(rx_b), .O_TX(tx),
    .I_TX_START(tx_start), .O_TRANSMIT_OFF_A(off_a),
    .O_TRANSMIT_OFF_B(off_b), .O_RECEIVER_ON_A(on_a),
    .O_RECEIVER_ON_B(on_b));

  dbsmr_host_model i_dbsmr_host_model (
    .i_clk(clk), .o_strobe_n(strobe_n), .o_reg_sel(reg_sel),
    .o_read_nwrite(rnw), .o_bus_select(sel_pin), .o_data(h_data),
    .o_data_oe(h_data_oe), .o_sync(h_sync), .o_sync_oe(h_sync_oe),
    .i_data(data_w), .i_sync(sync_w), .o_result(h_result),
    .o_done(h_done));

  task automatic check(input string nm, input logic [17:0] seen,
                       input logic [17:0] exp);
    checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check

  task automatic conclude();
    if (n_errors == 0 && checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : conclude

  function automatic logic [WORD_W-1:0] sw(input logic w15);
    return {w15, st, 1'b0, cfg};
  endfunction : sw

  task automatic rd_status(input logic w15);
    exp_rd.push_back({1'b0, sw(w15)});
    i_dbsmr_host_model.access(1'b1, 1'b1, 1'b0, 1'b0, 16'h0000);
  endtask : rd_status

  task automatic wr_status(input logic [WORD_W-1:0] d);
    cfg = d[5:0];
    i_dbsmr_host_model.access(1'b0, 1'b1, 1'b0, 1'b0, d);
  endtask : wr_status

  task automatic rd_rx(input logic sel, input logic sy,
                       input logic [WORD_W-1:0] w);
    exp_rd.push_back({sy, w});
    i_dbsmr_host_model.access(1'b1, 1'b0, sel, 1'b0, 16'h0000);
  endtask : rd_rx

  task automatic wr_tx(input logic sel, input logic sy,
                       input logic [WORD_W-1:0] w);
    exp_tx.push_back({sel | cfg[5], sy | cfg[4], w});
    i_dbsmr_host_model.access(1'b0, 1'b0, sel, sy, w);
  endtask : wr_tx

  // kind 0 good word, 1 bad word, 2 word start
  task automatic rx_ev(input logic b, input int kind, input logic cmd,
                       input logic [WORD_W-1:0] w);
    dbsmr_rx_t r;
    r = b ? rx_b : rx_a;
    r.word_ok = (kind == 0);
    r.word_bad = (kind == 1);
    r.word_begin = (kind == 2);
    r.sync_cmd = cmd;
    r.word = w;
    @(posedge clk);
    if (b) rx_b <= r; else rx_a <= r;
    r.word_ok = 1'b0;
    r.word_bad = 1'b0;
    r.word_begin = 1'b0;
    r.sync_cmd = ~cmd;
    r.word = ~w;
    @(posedge clk);
    if (b) rx_b <= r; else rx_a <= r;
    repeat (2) @(posedge clk);
  endtask : rx_ev

  task automatic flags(input logic ea, input logic eb, input logic ef);
    #1;
    check("word arrived a", arr_a, ea);
    check("word arrived b", arr_b, eb);
    check("decode fault", fault, ef);
  endtask : flags

  always @(posedge clk) begin
    if (h_done === 1'b1)
      check("read word", {1'b0, h_result}, {1'b0, exp_rd.pop_front()});
    if (tx.go === 1'b1)
      check("tx request", {tx.bus_b, tx.sync_cmd, tx.word},
            exp_tx.pop_front());
  end

  always @(posedge clk) begin
    cycles++;
    if (cycles == 6000) begin
      n_errors++;
      conclude();
    end
  end

  initial begin
    logic [WORD_W-1:0] w;
    logic [3:0]        k;
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    #1;
    check("config pins", {off_a, off_b, on_a, on_b}, 18'h3);
    flags(1'b0, 1'b0, 1'b0);
    rd_status(1'b1);
    for (int i = 0; i < 6; i++) begin
      wr_status(16'hffc0 | (16'h0001 << i));
      #1;
      check("config pins", {on_b, on_a, off_b, off_a}, cfg[3:0]);
      rd_status(1'b1);
    end
    for (int i = 0; i < 16; i++) begin
      k = i[3:0];
      wr_status({10'h000, k[3:2], 4'hc});
      wr_tx(k[1], k[0], WORD_W'($random(seed)));
    end
    wr_status(16'h000c);
    w = WORD_W'($random(seed));
    rx_ev(1'b0, 0, 1'b1, w);
    flags(1'b1, 1'b0, 1'b0);
    st[1:0] = 2'b11;
    rd_status(1'b1);
    rd_rx(1'b0, 1'b1, w);
    st[0] = 1'b0;
    flags(1'b0, 1'b0, 1'b0);
    w = WORD_W'($random(seed));
    rx_ev(1'b1, 0, 1'b0, w);
    flags(1'b0, 1'b1, 1'b0);
    wr_status(16'h002c);
    rd_rx(1'b0, 1'b0, w);
    flags(1'b0, 1'b0, 1'b0);
    wr_status(16'h000c);
    w = WORD_W'($random(seed));
    rx_ev(1'b0, 0, 1'b0, w);
    rx_ev(1'b0, 2, 1'b0, 16'h0000);
    flags(1'b0, 1'b0, 1'b0);
    rd_rx(1'b0, 1'b0, w);
    w = WORD_W'($random(seed));
    rx_ev(1'b0, 0, 1'b1, w);
    rd_rx(1'b0, 1'b1, w);
    rx_ev(1'b0, 1, 1'b0, WORD_W'($random(seed)));
    flags(1'b0, 1'b0, 1'b1);
    st[3] = 1'b1;
    rd_status(1'b1);
    w = WORD_W'($random(seed));
    rx_ev(1'b0, 0, 1'b0, w);
    flags(1'b1, 1'b0, 1'b0);
    st[3:0] = 4'b0100;
    rd_rx(1'b0, 1'b0, w);
    @(posedge clk);
    rx_a.line_busy <= 1'b1;
    repeat (3) @(posedge clk);
    st[2] = 1'b0;
    rd_status(1'b1);
    rx_a.line_busy <= 1'b0;
    repeat (3) @(posedge clk);
    st[2] = 1'b1;
    wr_status(16'h0008);
    rx_ev(1'b0, 0, 1'b1, WORD_W'($random(seed)));
    flags(1'b0, 1'b0, 1'b0);
    rd_status(1'b1);
    wr_status(16'h000c);
    @(posedge clk);
    tx_start <= 1'b1;
    @(posedge clk);
    tx_start <= 1'b0;
    rd_status(1'b0);
    repeat (40) @(posedge clk);
    rd_status(1'b1);
    repeat (60) @(posedge clk);
    rd_status(1'b0);
    repeat (30) @(posedge clk);
    rd_status(1'b1);
    repeat (4) @(posedge clk);
    conclude();
  end
endmodule : test_dual_bus_status_mode_register
